// ### hdl/swp_pkg.sv
package swp_pkg;

  // Clock and timing
  localparam int          SYS_CLK_KHZ   = 20000;
  localparam int          SYS_CLK_NS    = 50;
  localparam int          WAKE_HOLD_US  = 500;
  localparam int          WAKE_HOLD_CYC = WAKE_HOLD_US * SYS_CLK_KHZ / 1000;
  localparam int          COPY_NS       = 7000;
  localparam int          COPY_CYC      = (COPY_NS + SYS_CLK_NS - 1)
                                          / SYS_CLK_NS;
  // Low-power oscillator edges that cover crystal start-up
  localparam logic [15:0] RST_LP_EDGES  = 16'h0010;
  localparam int          TMR_W         = 16;
  localparam int          SYNC_W        = 4;

  // Synchroniser bit positions
  localparam int          SY_POR        = 0;
  localparam int          SY_LP         = 1;
  localparam int          SY_WAKE       = 2;
  localparam int          SY_CS         = 3;

  // Reset configuration
  localparam logic [3:0]  DEF_CHANNEL   = 4'h5;
  localparam logic [4:0]  DEF_PCODE     = 5'h04;
  localparam logic [1:0]  DEF_RATE      = 2'h2;  // 6.8 Mbps
  localparam logic [1:0]  DEF_PRF       = 2'h1;  // 16 MHz
  localparam logic [11:0] DEF_PRE_LEN   = 12'h080;
  localparam logic [7:0]  DEF_LDO_TRIM  = 8'h00;

  typedef enum logic [10:0] {
    ST_OFF    = 11'h001,
    ST_RST    = 11'h002,
    ST_WAKEUP = 11'h004,
    ST_IDLE   = 11'h008,
    ST_INIT   = 11'h010,
    ST_RX     = 11'h020,
    ST_TX     = 11'h040,
    ST_SAVE   = 11'h080,
    ST_SLEEP  = 11'h100,
    ST_DEEP   = 11'h200,
    ST_SNOOZE = 11'h400
  } swp_state_e;

  typedef enum logic [1:0] {
    HS_IDLE = 2'h1,
    HS_HOLD = 2'h2
  } swp_hstate_e;

endpackage

// ### hdl/swp_link_if.sv
interface swp_link_if;
  logic wake_line;
  logic host_select_n;
  logic host_serial_in;
  logic ext_device_enable;
  logic cfg_busy;

  modport dev (
    input  wake_line,
    input  host_select_n,
    input  host_serial_in,
    output ext_device_enable,
    output cfg_busy
  );

  modport hst (
    output wake_line,
    output host_select_n,
    output host_serial_in,
    input  ext_device_enable,
    input  cfg_busy
  );
endinterface

// ### hdl/swp_dev.sv
// Function
// - Supply above threshold enables crystal and ext_device_enable
// - Low-power oscillator counter holds core in reset
// - WAKEUP starts synthesiser, waits lock, enters IDLE
// - DEEPSLEEP exits only on wake line or select
// - SLEEP timer on ring oscillator; pins also wake
// - Measure oscillator period in halved crystal cycles
// - Wake line hold wakes only if pin enable
// - Select hold wakes only if select enable
// - Host keeps serial input low during select wake
// - Timer wakes only with enable and nonzero period
// - Every wake reaches IDLE, then configured transitions
// - Copy config to store before sleep, back in WAKEUP
// - Restore in WAKEUP only when restore enable set
// - Host avoids register access during config copy
// - Host sets trim load bit from OTP byte
// - Trim load bit copies trim value each wake
// - Sniff alternates receive on and IDLE off
// - Low duty sniff spends off period in INIT
// - Low-power listening sleeps, wakes briefly to receive
// - Reset config channel 5, code 4, 6.8M, 16M, 128
// - SNOOZE counts crystal cycles, then INIT, IDLE, receive
// - Auto sleep after tx/rx unless interrupt pending
module swp_dev (
  input  wire logic                       sys_clk,
  input  wire logic                       nrst,
  swp_link_if.dev                         link,
  input  wire logic                       por_ok,
  input  wire logic                       lp_osc,
  input  wire logic                       synth_lock,
  input  wire logic                       wake_on_pin_en,
  input  wire logic                       wake_on_cs_en,
  input  wire logic                       wake_on_timer_en,
  input  wire logic [swp_pkg::TMR_W-1:0]  sleep_period,
  input  wire logic                       restore_on_wake_en,
  input  wire logic                       load_ldo_trim_on_wake,
  input  wire logic [7:0]                 ldo_trim_value,
  input  wire logic                       auto_sleep_after_tx,
  input  wire logic                       auto_sleep_after_rx,
  input  wire logic                       deep_sel,
  input  wire logic                       irq_pending,
  input  wire logic                       sleep_req,
  input  wire logic                       tx_start,
  input  wire logic                       tx_done,
  input  wire logic                       rx_start,
  input  wire logic                       rx_done,
  input  wire logic                       sniff_en,
  input  wire logic                       ldc_sniff_en,
  input  wire logic                       lpl_en,
  input  wire logic [swp_pkg::TMR_W-1:0]  rx_on_time,
  input  wire logic [swp_pkg::TMR_W-1:0]  rx_off_time,
  input  wire logic                       snooze_req,
  input  wire logic [swp_pkg::TMR_W-1:0]  snooze_count,
  output swp_pkg::swp_state_e             state_q,
  output logic                            xtal_en_q,
  output logic                            core_rst_n_q,
  output logic                            synth_en_q,
  output logic [7:0]                      ldo_trim_register_q,
  output logic [swp_pkg::TMR_W-1:0]       lp_period_q,
  output logic [3:0]                      channel_q,
  output logic [4:0]                      pcode_q,
  output logic [1:0]                      data_rate_q,
  output logic [1:0]                      prf_q,
  output logic [11:0]                     preamble_len_q
);

  logic [swp_pkg::SYNC_W-1:0] sy1_q;
  logic [swp_pkg::SYNC_W-1:0] sy2_q;
  logic [swp_pkg::SYNC_W-1:0] sy3_q;
  logic [swp_pkg::TMR_W-1:0]  tmr_q;
  logic [swp_pkg::TMR_W-1:0]  lp_cnt_q;
  logic [swp_pkg::TMR_W-1:0]  meas_q;
  logic                       restored_q;
  logic                       rx_pend_q;
  logic                       off_q;
  logic                       lp_rise;
  logic                       pin_ev;
  logic                       cs_ev;
  logic                       tmr_ev;
  logic                       timed_rx;
  logic                       wake_ev;

  // Pin inputs, two flops each; third stage only for edges
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sy1_q <= '0;
      sy2_q <= '0;
      sy3_q <= '0;
    end
    else
    begin
      sy1_q <= {link.host_select_n, link.wake_line, lp_osc, por_ok};
      sy2_q <= sy1_q;
      sy3_q <= sy2_q;
    end
  end

  // One event per assertion, disabled sources dropped
  assign lp_rise  = sy2_q[swp_pkg::SY_LP] & ~sy3_q[swp_pkg::SY_LP];
  assign pin_ev   = wake_on_pin_en & sy2_q[swp_pkg::SY_WAKE]
                    & ~sy3_q[swp_pkg::SY_WAKE];
  assign cs_ev    = wake_on_cs_en & ~sy2_q[swp_pkg::SY_CS]
                    & sy3_q[swp_pkg::SY_CS];
  assign tmr_ev   = wake_on_timer_en && (sleep_period != '0)
                    && (lp_cnt_q == sleep_period);
  assign wake_ev  = pin_ev | cs_ev;
  assign timed_rx = sniff_en | lpl_en;

  // Main state sequence
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_q    <= swp_pkg::ST_OFF;
      tmr_q      <= '0;
      lp_cnt_q   <= '0;
      restored_q <= 1'b0;
      rx_pend_q  <= 1'b0;
      off_q      <= 1'b0;
    end
    else if (!sy2_q[swp_pkg::SY_POR])
    begin
      // Supply loss drops everything back to off
      state_q    <= swp_pkg::ST_OFF;
      tmr_q      <= '0;
      lp_cnt_q   <= '0;
      restored_q <= 1'b0;
      rx_pend_q  <= 1'b0;
      off_q      <= 1'b0;
    end
    else
    begin
      case (state_q)
        swp_pkg::ST_OFF:
        begin
          state_q  <= swp_pkg::ST_RST;
          lp_cnt_q <= '0;
        end
        swp_pkg::ST_RST:
        begin
          if (lp_rise)
          begin
            lp_cnt_q <= lp_cnt_q + 1'b1;
            if (lp_cnt_q == swp_pkg::RST_LP_EDGES - 1'b1)
            begin
              state_q    <= swp_pkg::ST_WAKEUP;
              tmr_q      <= '0;
              restored_q <= 1'b0;
            end
          end
        end
        swp_pkg::ST_WAKEUP:
        begin
          if (restore_on_wake_en && !restored_q)
          begin
            if (tmr_q == swp_pkg::TMR_W'(swp_pkg::COPY_CYC - 1))
              restored_q <= 1'b1;
            tmr_q <= tmr_q + 1'b1;
          end
          else if (synth_lock)
          begin
            state_q <= swp_pkg::ST_IDLE;
            tmr_q   <= '0;
          end
        end
        swp_pkg::ST_IDLE, swp_pkg::ST_INIT:
        begin
          if (off_q)
          begin
            // Off half of a sniff period
            tmr_q <= tmr_q + 1'b1;
            if (tmr_q >= rx_off_time || !sniff_en)
            begin
              off_q   <= 1'b0;
              tmr_q   <= '0;
              state_q <= sniff_en ? swp_pkg::ST_RX
                                  : swp_pkg::ST_IDLE;
            end
          end
          else if (state_q == swp_pkg::ST_INIT)
            state_q <= swp_pkg::ST_IDLE;
          else if (rx_pend_q)
          begin
            rx_pend_q <= 1'b0;
            tmr_q     <= '0;
            state_q   <= swp_pkg::ST_RX;
          end
          else if (tx_start)
            state_q <= swp_pkg::ST_TX;
          else if (rx_start || sniff_en)
          begin
            tmr_q   <= '0;
            state_q <= swp_pkg::ST_RX;
          end
          else if (snooze_req)
          begin
            tmr_q   <= '0;
            state_q <= swp_pkg::ST_SNOOZE;
          end
          else if (sleep_req || lpl_en)
          begin
            tmr_q   <= '0;
            state_q <= swp_pkg::ST_SAVE;
          end
        end
        swp_pkg::ST_RX:
        begin
          tmr_q <= tmr_q + 1'b1;
          if (rx_done)
          begin
            tmr_q   <= '0;
            state_q <= (auto_sleep_after_rx && !irq_pending)
                       ? swp_pkg::ST_SAVE : swp_pkg::ST_IDLE;
          end
          else if (timed_rx && tmr_q >= rx_on_time)
          begin
            tmr_q <= '0;
            if (lpl_en)
              state_q <= swp_pkg::ST_SAVE;
            else
            begin
              off_q   <= 1'b1;
              state_q <= ldc_sniff_en ? swp_pkg::ST_INIT
                                      : swp_pkg::ST_IDLE;
            end
          end
        end
        swp_pkg::ST_TX:
        begin
          if (tx_done)
          begin
            tmr_q   <= '0;
            state_q <= (auto_sleep_after_tx && !irq_pending)
                       ? swp_pkg::ST_SAVE : swp_pkg::ST_IDLE;
          end
        end
        swp_pkg::ST_SAVE:
        begin
          tmr_q <= tmr_q + 1'b1;
          if (tmr_q == swp_pkg::TMR_W'(swp_pkg::COPY_CYC - 1))
          begin
            tmr_q    <= '0;
            lp_cnt_q <= '0;
            state_q  <= deep_sel ? swp_pkg::ST_DEEP : swp_pkg::ST_SLEEP;
          end
        end
        swp_pkg::ST_SLEEP:
        begin
          if (lp_rise)
            lp_cnt_q <= lp_cnt_q + 1'b1;
          if (wake_ev || tmr_ev)
          begin
            state_q    <= swp_pkg::ST_WAKEUP;
            restored_q <= 1'b0;
            tmr_q      <= '0;
            rx_pend_q  <= lpl_en;
          end
        end
        swp_pkg::ST_DEEP:
        begin
          // No timer exit from this state
          if (wake_ev)
          begin
            state_q    <= swp_pkg::ST_WAKEUP;
            restored_q <= 1'b0;
            tmr_q      <= '0;
            rx_pend_q  <= lpl_en;
          end
        end
        swp_pkg::ST_SNOOZE:
        begin
          tmr_q <= tmr_q + 1'b1;
          if (tmr_q >= snooze_count)
          begin
            tmr_q     <= '0;
            rx_pend_q <= 1'b1;
            state_q   <= swp_pkg::ST_INIT;
          end
        end
        default:
          state_q <= swp_pkg::ST_OFF;
      endcase
    end
  end

  // Power, reset and link outputs
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      xtal_en_q              <= 1'b0;
      link.ext_device_enable <= 1'b0;
      core_rst_n_q           <= 1'b0;
      synth_en_q             <= 1'b0;
      link.cfg_busy          <= 1'b0;
    end
    else
    begin
      xtal_en_q              <= sy2_q[swp_pkg::SY_POR];
      link.ext_device_enable <= sy2_q[swp_pkg::SY_POR];
      core_rst_n_q           <= !(state_q == swp_pkg::ST_OFF
                                  || state_q == swp_pkg::ST_RST);
      synth_en_q             <= !(state_q == swp_pkg::ST_OFF
                                  || state_q == swp_pkg::ST_RST
                                  || state_q == swp_pkg::ST_SLEEP
                                  || state_q == swp_pkg::ST_DEEP
                                  || state_q == swp_pkg::ST_SNOOZE
                                  || state_q == swp_pkg::ST_INIT);
      link.cfg_busy          <= state_q == swp_pkg::ST_SAVE
                                || (state_q == swp_pkg::ST_WAKEUP
                                    && restore_on_wake_en
                                    && !restored_q);
    end
  end

  // Trim reload in WAKEUP while its timer is zero: first cycle, or every cycle without restore
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      ldo_trim_register_q <= swp_pkg::DEF_LDO_TRIM;
    else if (state_q == swp_pkg::ST_WAKEUP && tmr_q == '0
             && load_ldo_trim_on_wake)
      ldo_trim_register_q <= ldo_trim_value;
  end

  // Counted on the system clock, which stands for halved crystal
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      meas_q      <= '0;
      lp_period_q <= '0;
    end
    else if (lp_rise)
    begin
      lp_period_q <= meas_q + 1'b1;
      meas_q      <= '0;
    end
    else if (meas_q != '1)
      meas_q <= meas_q + 1'b1; // Saturates if oscillator stops
  end

  // Radio defaults after power-up
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      channel_q      <= swp_pkg::DEF_CHANNEL;
      pcode_q        <= swp_pkg::DEF_PCODE;
      data_rate_q    <= swp_pkg::DEF_RATE;
      prf_q          <= swp_pkg::DEF_PRF;
      preamble_len_q <= swp_pkg::DEF_PRE_LEN;
    end
    else if (state_q == swp_pkg::ST_OFF)
    begin
      channel_q      <= swp_pkg::DEF_CHANNEL;
      pcode_q        <= swp_pkg::DEF_PCODE;
      data_rate_q    <= swp_pkg::DEF_RATE;
      prf_q          <= swp_pkg::DEF_PRF;
      preamble_len_q <= swp_pkg::DEF_PRE_LEN;
    end
  end

endmodule // swp_dev

// ### hdl/swp_host.sv
module swp_host #(
  parameter int WAKE_HOLD_CYC = swp_pkg::WAKE_HOLD_CYC
) (
  input  wire logic       sys_clk,
  input  wire logic       nrst,
  swp_link_if.hst         link,
  input  wire logic       wake_req,
  input  wire logic       use_cs,
  input  wire logic       ser_data,
  input  wire logic [7:0] otp_first_byte,
  output logic            busy_q,
  output logic            load_ldo_trim_on_wake_q,
  output logic            reg_access_ok_q
);

  swp_pkg::swp_hstate_e st_q;
  logic [15:0]          cnt_q;
  logic                 by1_q;
  logic                 by2_q;

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_q               <= swp_pkg::HS_IDLE;
      cnt_q              <= '0;
      busy_q             <= 1'b0;
      link.wake_line     <= 1'b0;
      link.host_select_n <= 1'b1;
      link.host_serial_in <= 1'b0;
    end
    else
    begin
      case (st_q)
        swp_pkg::HS_IDLE:
        begin
          link.host_serial_in <= ser_data;
          if (wake_req)
          begin
            st_q                <= swp_pkg::HS_HOLD;
            cnt_q               <= '0;
            busy_q              <= 1'b1;
            link.wake_line      <= !use_cs;
            link.host_select_n  <= !use_cs;
            link.host_serial_in <= 1'b0;
          end
        end
        swp_pkg::HS_HOLD:
        begin
          cnt_q               <= cnt_q + 1'b1;
          link.host_serial_in <= 1'b0;
          if (cnt_q == 16'(WAKE_HOLD_CYC - 1))
          begin
            st_q               <= swp_pkg::HS_IDLE;
            busy_q             <= 1'b0;
            link.wake_line     <= 1'b0;
            link.host_select_n <= 1'b1;
          end
        end
        default:
          st_q <= swp_pkg::HS_IDLE;
      endcase
    end
  end

  // Busy comes from the other chip, so it is synchronised
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      by1_q                   <= 1'b1;
      by2_q                   <= 1'b1;
      reg_access_ok_q         <= 1'b0;
      load_ldo_trim_on_wake_q <= 1'b0;
    end
    else
    begin
      by1_q                   <= link.cfg_busy;
      by2_q                   <= by1_q;
      reg_access_ok_q         <= !by2_q;
      load_ldo_trim_on_wake_q <= otp_first_byte != 8'h00;
    end
  end

endmodule // swp_host

// ### bench/swp_asserts.sv
module swp_asserts #(
  parameter int HOLD = swp_pkg::WAKE_HOLD_CYC,
  parameter int COPY = swp_pkg::COPY_CYC
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic wake_line,
  input wire logic host_select_n,
  input wire logic host_serial_in,
  input wire logic ext_device_enable,
  input wire logic cfg_busy
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [15:0] wk_q;
  logic [15:0] cs_q;
  logic [15:0] bz_q;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  // Hold lengths exceed any repetition count, so count them
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst) wk_q <= '0;
    else wk_q <= wake_line ? wk_q + 16'h0001 : 16'h0000;
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst) cs_q <= '0;
    else cs_q <= !host_select_n ? cs_q + 16'h0001 : 16'h0000;
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst) bz_q <= '0;
    else bz_q <= cfg_busy ? bz_q + 16'h0001 : 16'h0000;
  end

  a_wake_hold_len : assert property (
    $fell(wake_line) |-> wk_q == 16'(HOLD))
    else $error("wake line hold length wrong");
  a_wake_hold_min : assert property (
    $rose(wake_line) |-> wake_line [*8])
    else $error("wake line dropped early");
  a_sel_hold_len : assert property (
    $rose(host_select_n) |-> cs_q == 16'(HOLD))
    else $error("select hold length wrong");
  a_one_source : assert property (
    !(wake_line && !host_select_n))
    else $error("both wake sources driven");
  a_sel_serial_low : assert property (
    !host_select_n |-> !host_serial_in)
    else $error("serial input high during select wake");
  a_sel_quiet_in : assert property (
    $fell(host_select_n) |-> (!host_select_n && !host_serial_in) [*8])
    else $error("select wake not held quiet");
  a_copy_len : assert property (
    $fell(cfg_busy) |-> bz_q == 16'(COPY))
    else $error("config copy length wrong");
  a_copy_powered : assert property (
    cfg_busy |-> ext_device_enable)
    else $error("copy while device disabled");
endmodule // swp_asserts

// ### bench/tb.sv
`define CHK(nm, ex, got) \
  begin \
    compares++; \
    if ((got) !== (ex)) \
    begin \
      error_cnt++; \
      $display("[FAIL] %s exp %0h got %0h", nm, ex, got); \
    end \
  end

module tb;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int HOLD = 20;
  logic sys_clk = 1'b0, nrst = 1'b0, por_ok = 1'b0, lp_osc = 1'b0;
  logic synth_lock = 1'b0, pin_en = 1'b0, cs_en = 1'b0, tmr_en = 1'b0;
  logic restore = 1'b1, ld_trim, as_tx = 1'b0, as_rx = 1'b0, deep_sel = 1'b0;
  logic irq_pending = 1'b0, sleep_req = 1'b0, tx_start = 1'b0;
  logic tx_done = 1'b0, rx_start = 1'b0, rx_done = 1'b0, sniff_en = 1'b0;
  logic ldc_en = 1'b0, snooze_req = 1'b0, wake_req = 1'b0, use_cs = 1'b0;
  logic lpl_en = 1'b0;
  logic ser_data = 1'b0, xtal_en, core_rst_n, synth_en, busy, acc_ok;
  logic [15:0] sleep_period = '0, snooze_count = '0, lp_period;
  logic [7:0]  trim_val = '0, otp_byte = 8'h01, trim_reg, t;
  logic [3:0]  channel;
  logic [4:0]  pcode;
  logic [1:0]  rate, prf;
  logic [11:0] pre_len;
  int          error_cnt = 0, compares = 0, lp_cnt = 0, n;
  logic        seen_busy = 1'b0;
  swp_pkg::swp_state_e state_q, prev_st, exp_st, off;
  swp_pkg::swp_state_e exp_q[$];

  swp_link_if link();
  swp_dev swp_dev_inst (.sys_clk(sys_clk), .nrst(nrst), .link(link),
    .por_ok(por_ok), .lp_osc(lp_osc), .synth_lock(synth_lock),
    .wake_on_pin_en(pin_en), .wake_on_cs_en(cs_en),
    .wake_on_timer_en(tmr_en), .sleep_period(sleep_period),
    .restore_on_wake_en(restore), .load_ldo_trim_on_wake(ld_trim),
    .ldo_trim_value(trim_val), .auto_sleep_after_tx(as_tx),
    .auto_sleep_after_rx(as_rx), .deep_sel(deep_sel),
    .irq_pending(irq_pending), .sleep_req(sleep_req),
    .tx_start(tx_start), .tx_done(tx_done), .rx_start(rx_start),
    .rx_done(rx_done), .sniff_en(sniff_en), .ldc_sniff_en(ldc_en),
    .lpl_en(lpl_en), .rx_on_time(16'h0003), .rx_off_time(16'h0004),
    .snooze_req(snooze_req), .snooze_count(snooze_count),
    .state_q(state_q), .xtal_en_q(xtal_en), .core_rst_n_q(core_rst_n),
    .synth_en_q(synth_en), .ldo_trim_register_q(trim_reg),
    .lp_period_q(lp_period), .channel_q(channel), .pcode_q(pcode),
    .data_rate_q(rate), .prf_q(prf), .preamble_len_q(pre_len));
  swp_host #(.WAKE_HOLD_CYC(HOLD)) swp_host_inst (.sys_clk(sys_clk),
    .nrst(nrst), .link(link), .wake_req(wake_req), .use_cs(use_cs),
    .ser_data(ser_data), .otp_first_byte(otp_byte), .busy_q(busy),
    .load_ldo_trim_on_wake_q(ld_trim), .reg_access_ok_q(acc_ok));
  swp_asserts #(.HOLD(HOLD), .COPY(swp_pkg::COPY_CYC)) swp_asserts_inst (
    .sys_clk(sys_clk), .nrst(nrst), .wake_line(link.wake_line),
    .host_select_n(link.host_select_n),
    .host_serial_in(link.host_serial_in),
    .ext_device_enable(link.ext_device_enable), .cfg_busy(link.cfg_busy));

  always #25 sys_clk = ~sys_clk;

  // Ring oscillator stand-in: 18 clock period, far faster than real
  always @(posedge sys_clk)
  begin
    lp_cnt <= (lp_cnt == 8) ? 0 : lp_cnt + 1;
    if (lp_cnt == 8) lp_osc <= ~lp_osc;
    ser_data <= 1'($urandom);
  end

  // Every state change must match the oldest noted expectation
  always @(negedge sys_clk)
  begin
    if (nrst && state_q !== prev_st)
    begin
      exp_st = (exp_q.size() == 0) ? prev_st : exp_q.pop_front();
      `CHK("state", exp_st, state_q)
    end
    if (state_q === swp_pkg::ST_WAKEUP && link.cfg_busy === 1'b1)
      seen_busy = 1'b1;
    prev_st = state_q;
  end

  task automatic wait_st(swp_pkg::swp_state_e s);
    for (int i = 0; i < 4000 && state_q !== s; i++) @(negedge sys_clk);
    `CHK("wait", s, state_q)
    @(posedge sys_clk);
  endtask

  task automatic pin_wake(logic cs);
    @(posedge sys_clk);
    use_cs <= cs;
    @(posedge sys_clk);
    wake_req <= 1'b1;
    @(posedge sys_clk);
    wake_req <= 1'b0;
    repeat (HOLD + 4) @(posedge sys_clk);
    `CHK("host_busy", 1'b0, busy)
  endtask

  task automatic go_sleep(swp_pkg::swp_state_e s);
    exp_q = {swp_pkg::ST_SAVE, s};
    @(posedge sys_clk);
    sleep_req <= 1'b1;
    @(posedge sys_clk);
    sleep_req <= 1'b0;
    wait_st(s);
  endtask

  task automatic print_verdict;
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial
  begin
    #2500000;
    error_cnt++;
    $display("[FAIL] watchdog exp done got hang");
    print_verdict;
  end

  initial
  begin
    void'($urandom(32'had5412d6));
    trim_val <= 8'($urandom);
    otp_byte <= 8'($urandom_range(255, 1));
    repeat (20) @(posedge sys_clk);
    nrst <= 1'b1;
    @(negedge sys_clk);
    `CHK("channel", 4'h5, channel)
    `CHK("pcode", 5'h04, pcode)
    `CHK("rate", 2'h2, rate)
    `CHK("prf", 2'h1, prf)
    `CHK("pre_len", 12'h080, pre_len)
    exp_q = {swp_pkg::ST_RST, swp_pkg::ST_WAKEUP, swp_pkg::ST_IDLE};
    @(posedge sys_clk);
    por_ok <= 1'b1;
    wait_st(swp_pkg::ST_RST);
    `CHK("ext_en", 1'b1, link.ext_device_enable)
    `CHK("xtal_en", 1'b1, xtal_en)
    `CHK("core_rst", 1'b0, core_rst_n)
    for (n = 0; n < 400 && state_q === swp_pkg::ST_RST; n++)
      @(negedge sys_clk);
    `CHK("rst_len", 1'b1, n >= 270 && n <= 292)
    @(negedge sys_clk);
    `CHK("core_rst", 1'b1, core_rst_n)
    `CHK("synth_en", 1'b1, synth_en)
    repeat (200) @(negedge sys_clk);
    `CHK("lock_wait", swp_pkg::ST_WAKEUP, state_q)
    `CHK("restore", 1'b1, seen_busy)
    `CHK("trim", trim_val, trim_reg)
    @(posedge sys_clk);
    synth_lock <= 1'b1;
    wait_st(swp_pkg::ST_IDLE);
    `CHK("lp_period", 16'd18, lp_period)
    `CHK("acc_ok", 1'b1, acc_ok)
    $display("test power_up done");

    tmr_en <= 1'b1;
    sleep_period <= 16'd3;
    go_sleep(swp_pkg::ST_SAVE);
    repeat (20) @(negedge sys_clk);
    `CHK("acc_ok", 1'b0, acc_ok)
    `CHK("cfg_busy", 1'b1, link.cfg_busy)
    exp_q = {swp_pkg::ST_SLEEP, swp_pkg::ST_WAKEUP, swp_pkg::ST_IDLE};
    wait_st(swp_pkg::ST_IDLE);
    $display("test timer_wake done");

    // Timer stays armed: deep sleep must ignore it
    deep_sel <= 1'b1;
    sleep_period <= 16'd2;
    go_sleep(swp_pkg::ST_DEEP);
    repeat (300) @(posedge sys_clk);
    restore <= 1'b0;
    trim_val <= 8'($urandom);
    pin_en <= 1'b1;
    seen_busy = 1'b0;
    exp_q = {swp_pkg::ST_WAKEUP, swp_pkg::ST_IDLE};
    pin_wake(1'b0);
    wait_st(swp_pkg::ST_IDLE);
    `CHK("restore", 1'b0, seen_busy)
    `CHK("trim", trim_val, trim_reg)
    $display("test deep_pin_wake done");

    go_sleep(swp_pkg::ST_DEEP);
    pin_wake(1'b1);
    `CHK("cs_off", swp_pkg::ST_DEEP, state_q)
    pin_en <= 1'b0;
    pin_wake(1'b0);
    `CHK("pin_off", swp_pkg::ST_DEEP, state_q)
    t = trim_reg;
    otp_byte <= 8'h00;
    trim_val <= ~trim_reg;
    cs_en <= 1'b1;
    exp_q = {swp_pkg::ST_WAKEUP, swp_pkg::ST_IDLE};
    pin_wake(1'b1);
    wait_st(swp_pkg::ST_IDLE);
    `CHK("no_trim", t, trim_reg)
    $display("test select_wake done");

    for (int l = 0; l < 2; l++)
    begin
      off = l ? swp_pkg::ST_INIT : swp_pkg::ST_IDLE;
      exp_q = {swp_pkg::ST_RX, off, swp_pkg::ST_RX, off};
      if (l) exp_q.push_back(swp_pkg::ST_IDLE);
      @(posedge sys_clk);
      ldc_en <= 1'(l);
      sniff_en <= 1'b1;
      wait_st(swp_pkg::ST_RX);
      wait_st(off);
      for (n = 0; n < 50 && state_q === off; n++) @(negedge sys_clk);
      `CHK("off_len", 5, n)
      // Receive only times out while sniff or lpl is on, so stop in off time
      wait_st(off);
      sniff_en <= 1'b0;
      wait_st(swp_pkg::ST_IDLE);
      repeat (20) @(posedge sys_clk);
    end
    $display("test sniff done");

    as_tx <= 1'b1;
    as_rx <= 1'b1;
    irq_pending <= 1'b1;
    deep_sel <= 1'b0;
    tmr_en <= 1'b0;
    pin_en <= 1'b1;
    exp_q = {swp_pkg::ST_TX, swp_pkg::ST_IDLE};
    tx_start <= 1'b1;
    @(posedge sys_clk);
    tx_start <= 1'b0;
    wait_st(swp_pkg::ST_TX);
    tx_done <= 1'b1;
    @(posedge sys_clk);
    tx_done <= 1'b0;
    wait_st(swp_pkg::ST_IDLE);
    irq_pending <= 1'b0;
    exp_q = {swp_pkg::ST_RX, swp_pkg::ST_SAVE, swp_pkg::ST_SLEEP};
    rx_start <= 1'b1;
    @(posedge sys_clk);
    rx_start <= 1'b0;
    wait_st(swp_pkg::ST_RX);
    rx_done <= 1'b1;
    @(posedge sys_clk);
    rx_done <= 1'b0;
    wait_st(swp_pkg::ST_SLEEP);
    as_rx <= 1'b0;
    exp_q = {swp_pkg::ST_WAKEUP, swp_pkg::ST_IDLE};
    pin_wake(1'b0);
    wait_st(swp_pkg::ST_IDLE);
    $display("test auto_sleep done");

    snooze_count <= 16'd5;
    exp_q = {swp_pkg::ST_SNOOZE, swp_pkg::ST_INIT, swp_pkg::ST_IDLE,
             swp_pkg::ST_RX, swp_pkg::ST_IDLE};
    snooze_req <= 1'b1;
    @(posedge sys_clk);
    snooze_req <= 1'b0;
    wait_st(swp_pkg::ST_SNOOZE);
    for (n = 0; n < 50 && state_q === swp_pkg::ST_SNOOZE; n++)
      @(negedge sys_clk);
    `CHK("snooze_len", 6, n)
    wait_st(swp_pkg::ST_RX);
    rx_done <= 1'b1;
    @(posedge sys_clk);
    rx_done <= 1'b0;
    wait_st(swp_pkg::ST_IDLE);
    $display("test snooze done");

    exp_q = {swp_pkg::ST_SAVE, swp_pkg::ST_SLEEP, swp_pkg::ST_WAKEUP,
             swp_pkg::ST_IDLE, swp_pkg::ST_RX, swp_pkg::ST_SAVE,
             swp_pkg::ST_SLEEP};
    lpl_en <= 1'b1;
    wait_st(swp_pkg::ST_SLEEP);
    pin_wake(1'b0);
    wait_st(swp_pkg::ST_SAVE);
    lpl_en <= 1'b0;
    wait_st(swp_pkg::ST_SLEEP);
    $display("test lpl done");
    print_verdict;
  end
endmodule // tb
